// File: tsr_readout.v
`timescale 1ns/10ps
`include "tsr_consts.vh"
module tsr_readout #(
   parameter INTERVAL_CYC = `TSR_INTERVAL_US * `TSR_SYS_MHZ,
   parameter CONVERT_CYC  = `TSR_CONVERT_US * `TSR_SYS_MHZ
) (
   input  wire                        i_sys_clk,
   input  wire                        i_reset_n,
   input  wire                        i_temp_select_n,
   input  wire                        i_sclk,
   input  wire                        i_din,
   input  wire [`TSR_RES_WIDTH-1:0]   i_temp_sample,
   output reg                         o_dout,
   output reg                         o_dout_oe,
   output reg  [`TSR_CTRL_WIDTH-1:0]  o_temp_sensor_control,
   output reg                         o_lockout,
   output reg  [`TSR_RES_WIDTH-1:0]   o_result
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: two flops per pin before any logic looks at it
   // only the second flop of each pair is read anywhere
   localparam NUM_PINS = 3;
   localparam PIN_SEL  = 0;
   localparam PIN_SCLK = 1;
   localparam PIN_DIN  = 2;
   // select idles high so reset must not fake a frame opening
   localparam [NUM_PINS-1:0] PIN_IDLE = 3'h1;
   wire [NUM_PINS-1:0]       pin_raw;
   wire [NUM_PINS-1:0]       pin_sync;
   reg                       clk_prev_reg;
   assign pin_raw[PIN_SEL]  = i_temp_select_n;
   assign pin_raw[PIN_SCLK] = i_sclk;
   assign pin_raw[PIN_DIN]  = i_din;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
         reg [1:0] stage_reg;
         always @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               stage_reg <= {2{PIN_IDLE[gi]}};
            end else begin
               stage_reg <= {stage_reg[0], pin_raw[gi]};
            end
         end
         assign pin_sync[gi] = stage_reg[1];
      end
   endgenerate
   // sclk idles low, so a zero history avoids a false edge after reset
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clk_prev_reg <= 1'b0;
      end else begin
         clk_prev_reg <= pin_sync[PIN_SCLK];
      end
   end
   wire selected  = ~pin_sync[PIN_SEL];
   wire sclk_rise = selected & pin_sync[PIN_SCLK] & ~clk_prev_reg;
   wire sclk_fall = selected & ~pin_sync[PIN_SCLK] & clk_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // conversion timebase, run from the system clock alone
   // the serial clock never reaches it, so a slow host cannot stall a conversion
   wire                       converting;
   wire                       conv_start;
   wire                       conv_done;
   wire [`TSR_RES_WIDTH-1:0]  conv_value;
   reg                        sel_prev_reg;
   wire                       frame_end = sel_prev_reg & ~selected;

   tsr_converter #(
      .INTERVAL_CYC (INTERVAL_CYC),
      .CONVERT_CYC  (CONVERT_CYC),
      .RES_W        (`TSR_RES_WIDTH)
   ) u_conv (
      .i_sys_clk    (i_sys_clk),
      .i_reset_n    (i_reset_n),
      .i_restart    (frame_end),
      .i_sample     (i_temp_sample),
      .o_converting (converting),
      .o_conv_start (conv_start),
      .o_conv_done  (conv_done),
      .o_conv_value (conv_value)
   );

   ////////////////////////////////////////////////////////////////////////
   // lockout and result register
   reg                        lockout_next;
   reg [`TSR_RES_WIDTH-1:0]   result_next;
   wire                       access_in_conv = selected & converting;
   // access during a conversion wins over the clear at a start
   always @* begin
      lockout_next = o_lockout;
      if (access_in_conv) begin
         lockout_next = 1'b1;
      end else if (conv_start & ~selected) begin
         lockout_next = 1'b0;
      end
   end
   // value kept until a conversion completes unlocked, never mid-frame
   always @* begin
      result_next = o_result;
      if (conv_done & ~o_lockout & ~selected) begin
         result_next = conv_value;
      end
   end
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_prev_reg <= 1'b0;
         o_lockout    <= 1'b0;
      end else begin
         sel_prev_reg <= selected;
         o_lockout    <= lockout_next;
      end
   end
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_result <= `TSR_RES_RESET;
      end else begin
         o_result <= result_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial shifter
   // slot layout: leading zero, ten data slots, then bit 0 held to the end
   // clocks past the frame length are ignored so a long burst cannot wrap
   localparam CNT_W = 5;
   reg [CNT_W-1:0]            bit_cnt_reg;
   reg [CNT_W-1:0]            bit_cnt_next;
   reg [`TSR_RES_WIDTH-1:0]   shift_reg;
   reg [`TSR_RES_WIDTH-1:0]   shift_next;
   reg                        dout_next;
   reg                        dout_oe_next;
   reg [`TSR_CTRL_WIDTH-1:0]  control_next;
   wire                       frame_open = selected & ~sel_prev_reg;
   function slot_open;
      input [CNT_W-1:0] cnt;
      begin
         slot_open = (cnt < `TSR_FRAME_CLOCKS);
      end
   endfunction
   function data_slot;
      input [CNT_W-1:0] cnt;
      begin
         data_slot = (cnt < `TSR_RES_WIDTH);
      end
   endfunction
   // control bits shift in on the rising edges alongside the read
   always @* begin
      control_next = o_temp_sensor_control;
      if (sclk_rise && slot_open(bit_cnt_reg)) begin
         control_next = {o_temp_sensor_control[`TSR_CTRL_WIDTH-2:0],
                         pin_sync[PIN_DIN]};
      end
   end
   always @* begin
      bit_cnt_next = bit_cnt_reg;
      shift_next   = shift_reg;
      dout_next    = o_dout;
      dout_oe_next = o_dout_oe;
      if (!selected) begin
         bit_cnt_next = {CNT_W{1'b0}};
         dout_next    = 1'b0;
         dout_oe_next = 1'b0;
      end else begin
         if (frame_open) begin
            // snapshot so a late update cannot tear the frame
            shift_next   = o_result;
            dout_next    = 1'b0;
            dout_oe_next = 1'b1;
         end
         if (sclk_fall && slot_open(bit_cnt_reg)) begin
            bit_cnt_next = bit_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            if (data_slot(bit_cnt_reg)) begin
               dout_next  = shift_reg[`TSR_RES_TOP_BIT];
               shift_next = {shift_reg[`TSR_RES_TOP_BIT-1:0], 1'b0};
            end
            // past the last bit dout holds until select rises
         end
      end
   end
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bit_cnt_reg <= {CNT_W{1'b0}};
         shift_reg   <= `TSR_RES_RESET;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
      end
   end
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_dout    <= 1'b0;
         o_dout_oe <= 1'b0;
      end else begin
         o_dout    <= dout_next;
         o_dout_oe <= dout_oe_next;
      end
   end
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_temp_sensor_control <= `TSR_CTRL_RESET;
      end else begin
         o_temp_sensor_control <= control_next;
      end
   end
endmodule

// File: tsr_consts.vh
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH
// control register, eight bits, all held low by the host
`define TSR_CTRL_WIDTH      8
`define TSR_CTRL_RESET      8'h00
// result field, twos complement, quarter degree per count
`define TSR_RES_WIDTH       10
`define TSR_RES_TOP_BIT     9
`define TSR_RES_BOTTOM_BIT  0
`define TSR_RES_RESET       10'h000
// frame length in serial clocks and bit slots
`define TSR_FRAME_CLOCKS    16
`define TSR_LEAD_ZERO_SLOT  0
// timing, microseconds, and the system clock in MHz
`define TSR_SYS_MHZ         200
`define TSR_INTERVAL_US     350
`define TSR_CONVERT_US      25
`endif

// File: tsr_converter.v
`timescale 1ns/10ps
`include "tsr_consts.vh"
// internal timebase: interval wait, then a conversion window
module tsr_converter #(
   parameter INTERVAL_CYC = `TSR_INTERVAL_US * `TSR_SYS_MHZ,
   parameter CONVERT_CYC  = `TSR_CONVERT_US * `TSR_SYS_MHZ,
   parameter RES_W        = `TSR_RES_WIDTH
) (
   input  wire             i_sys_clk,
   input  wire             i_reset_n,
   input  wire             i_restart,
   input  wire [RES_W-1:0] i_sample,
   output reg              o_converting,
   output reg              o_conv_start,
   output reg              o_conv_done,
   output reg  [RES_W-1:0] o_conv_value
);
   reg [31:0] count_reg;
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_reg    <= 32'h0000_0000;
         o_converting <= 1'b0;
         o_conv_start <= 1'b0;
         o_conv_done  <= 1'b0;
         o_conv_value <= {RES_W{1'b0}};
      end else begin
         o_conv_start <= 1'b0;
         o_conv_done  <= 1'b0;
         if (i_restart) begin
            // oscillator restarts after a transfer: fresh result one window later
            count_reg    <= 32'h0000_0000;
            o_converting <= 1'b1;
            o_conv_start <= 1'b1;
         end else if (o_converting) begin
            if (count_reg == CONVERT_CYC - 1) begin
               count_reg    <= 32'h0000_0000;
               o_converting <= 1'b0;
               o_conv_done  <= 1'b1;
               o_conv_value <= i_sample;
            end else begin
               count_reg <= count_reg + 32'h0000_0001;
            end
         end else if (count_reg == INTERVAL_CYC - 1) begin
            count_reg    <= 32'h0000_0000;
            o_converting <= 1'b1;
            o_conv_start <= 1'b1;
         end else begin
            count_reg <= count_reg + 32'h0000_0001;
         end
      end
   end
endmodule

// File: tsr_host_model.sv
`timescale 1ns/10ps
module tsr_host_model (
   input  wire  i_dout,
   output logic o_select_n,
   output logic o_sclk,
   output logic o_din
);
   initial begin
      o_select_n = 1'b1;
      o_sclk     = 1'b0; // stands still between frames
      o_din      = 1'b0;
   end
   // select left low so the caller can look inside the frame
   task automatic frame(output logic [15:0] word);
      o_select_n = 1'b0;
      #40;
      for (int i = 0; i < 16; i++) begin
         o_sclk = 1'b1;
         #24;
         word = {word[14:0], i_dout};
         o_sclk = 1'b0;
         #24;
      end
   endtask
   task automatic release_sel();
      o_select_n = 1'b1;
   endtask
endmodule

// File: tsr_readout_assertions.sv
`timescale 1ns/10ps
module tsr_readout_assertions #(
   parameter INTERVAL_CYC = 200,
   parameter CONVERT_CYC  = 20
) (
   input wire       i_sys_clk,
   input wire       i_reset_n,
   input wire       i_temp_select_n,
   input wire       i_sclk,
   input wire [9:0] i_temp_sample,
   input wire       o_dout,
   input wire       o_dout_oe,
   input wire       o_lockout,
   input wire [9:0] o_result
);
   localparam int LO = CONVERT_CYC;
   localparam int HI = CONVERT_CYC + 12;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // four cycles covers the select synchroniser
   a_select_freeze: assert property ((!i_temp_select_n) [*4] |=> $stable(o_result))
      else $error("result moved while selected");
   a_lock_sticky: assert property ((!i_temp_select_n) [*4] ##0 o_lockout |=> o_lockout)
      else $error("lockout dropped while selected");
   a_lock_blocks: assert property (o_lockout |=> $stable(o_result))
      else $error("result moved while locked");
   a_result_src: assert property (!$stable(o_result) |-> o_result == $past(i_temp_sample, 2))
      else $error("result not from sample");
   a_fresh_result: assert property ($rose(i_temp_select_n) |-> ##[LO:HI]
      (o_result == i_temp_sample || !i_temp_select_n)) else $error("no fresh result");
   a_lead_zero: assert property ($fell(i_temp_select_n) |-> ##5 (o_dout_oe && !o_dout))
      else $error("no leading zero");
   a_release_oe: assert property ($rose(i_temp_select_n) |-> ##[1:5] !o_dout_oe)
      else $error("output not released");
   a_hold_bit: assert property ((i_sclk && !i_temp_select_n) [*3] |=> $stable(o_dout))
      else $error("output moved without clock fall");
endmodule
bind tsr_readout tsr_readout_assertions #(.INTERVAL_CYC(INTERVAL_CYC), .CONVERT_CYC(CONVERT_CYC))
   tsr_readout_assertions_inst (.i_sys_clk, .i_reset_n, .i_temp_select_n, .i_sclk,
   .i_temp_sample, .o_dout, .o_dout_oe, .o_lockout, .o_result);

// File: tsr_readout_tb.sv
`timescale 1ns/10ps
module tsr_readout_tb;
   logic        i_sys_clk, i_reset_n, i_temp_select_n, i_sclk, i_din, o_dout, o_dout_oe, o_lockout;
   logic [9:0]  i_temp_sample, o_result;
   logic [7:0]  o_temp_sensor_control;
   logic [15:0] word;
   int          num_errors = 0;
   int          samples_checked = 0;
   // a released line reads high, as a pulled-up host input would
   tsr_host_model tsr_host_model_inst (.i_dout(o_dout_oe ? o_dout : 1'b1),
      .o_select_n(i_temp_select_n),
      .o_sclk(i_sclk), .o_din(i_din));
   tsr_readout #(.INTERVAL_CYC(200), .CONVERT_CYC(20)) tsr_readout_inst (.i_sys_clk, .i_reset_n,
      .i_temp_select_n, .i_sclk, .i_din, .i_temp_sample, .o_dout, .o_dout_oe,
      .o_temp_sensor_control, .o_lockout, .o_result);
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   ///////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic read_frame(input logic [9:0] exp);
      tsr_host_model_inst.frame(word);
      cmp("frame", {1'b0, exp, {5{exp[0]}}}, word);
      cmp("control", 16'h0000, 16'(o_temp_sensor_control));
      idle(1);
   endtask
   task automatic test_autoconv();
      cmp("result", 16'h0000, 16'(o_result));
      i_temp_sample = 10'h064;
      idle(235);
      cmp("result", 16'h0064, 16'(o_result));
      read_frame(10'h064);
      tsr_host_model_inst.release_sel();
   endtask
   // second access lands inside the restart conversion on purpose
   task automatic test_lockout();
      i_temp_sample = 10'h360;
      idle(10);
      read_frame(10'h064);
      cmp("lockout", 16'h0001, 16'(o_lockout));
      tsr_host_model_inst.release_sel();
      idle(40);
      cmp("lockout", 16'h0000, 16'(o_lockout));
      cmp("result", 16'h0360, 16'(o_result));
   endtask
   task automatic test_codes();
      logic [9:0] codes [3] = '{10'h3FF, 10'h1F4, 10'h001};
      foreach (codes[i]) begin
         i_temp_sample = codes[i];
         idle(250);
         read_frame(codes[i]);
         tsr_host_model_inst.release_sel();
      end
   endtask
   initial begin
      #30000;
      num_errors++;
      end_sim();
   end
   initial begin
      i_reset_n = 1'b0;
      i_temp_sample = 10'h000;
      idle(4);
      i_reset_n = 1'b1;
      idle(1);
      test_autoconv();
      test_lockout();
      test_codes();
      end_sim();
   end
endmodule
